// >>> rtl/bsp_port.sv
// Function
// R1: write: select at t, four words t+1,t+2
// R2: read words on output edges t+1..t+3
// R3: burst walks start address upward
// R4: capture both input edges, launch both output
// R5: read select ignored right after read
// R6: second back-to-back same request ignored
// R7: 8-bit: selects gate low/high nibble
// R8: 18-bit: selects gate bits 8:0/17:9
// R9: all selects high leaves word unchanged
// R10: selects sampled for every data word
// R11: reset: deselected, read outputs off
// R12: stopped clocks hold all state
// R13: both deselected: nothing starts, outputs off
// R14: both selected from idle: read first
// R15: strapped output clocks: use input clocks
//
// file holds the write-pair fifo and the port top
// assumes the output clock is phase-locked to the input clock
`default_nettype none
//------------------------------------------------------------
// write pair fifo
//------------------------------------------------------------
module bsp_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];             // storage
	logic [AW-1:0] wp;                  // write pointer
	logic [AW-1:0] rp;                  // read pointer
	logic [AW:0]   cnt;                 // words held
	logic          push;
	logic          pop;
	assign in_ready_o  = (cnt != (AW+1)'(D));
	assign out_valid_o = (cnt != '0);
	assign out_data_o  = mem[rp];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	// pointers and fill level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push) wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
			if (pop) rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// storage has no reset
	always_ff @(posedge clk_i) begin
		if (push) mem[wp] <= in_data_i;
	end
endmodule
//------------------------------------------------------------
// port top
//------------------------------------------------------------
module bsp_port (
	input  wire logic                        mclk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic                        k_clk_i,                 // input clock, fall is the inverted rise
	input  wire logic                        c_clk_i,                 // output clock
	input  wire logic                        cb_clk_i,                // inverted output clock, strap only
	input  wire logic                        read_port_select_n_i,
	input  wire logic                        write_port_select_n_i,
	input  wire logic [bsp_pkg::BADDR_W-1:0] addr_i,
	input  wire logic [bsp_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic [bsp_pkg::MASK_W-1:0]  byte_write_mask_n_i,     // nibble_write_mask_n on the 8-bit part
	output logic      [bsp_pkg::DATA_W-1:0]  rdata_o,
	output logic                             rdata_oe_o,
	output logic                             wr_ready_o,
	output logic                             wr_backlog_o,
	output logic                             single_mode_o
);
	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic                        strap_s1, strap_s2;     // strap sampler
	logic                        strap_v1, strap_v2, strap_done; // sampler filled, strap taken once
	logic                        single_mode, oclk;      // output on input clocks, output register clock
	logic                        prev_rd, prev_wr;       // initiation in the last cycle
	logic                        rd_go, wr_go;           // initiation this edge
	logic                        rd_s1, ws1, ws2, ws3;   // read fetch stage, write data stages
	logic [bsp_pkg::BADDR_W-1:0] ra, wa;                 // latched burst addresses
	logic [bsp_pkg::WADDR_W-1:0] wnext;                  // address of the second pair
	logic [bsp_pkg::DATA_W-1:0]  d_lo, d_hi;             // words from rise and inverted rise
	logic [bsp_pkg::MASK_W-1:0]  m_lo, m_hi;             // their mask selects
	logic [bsp_pkg::DATA_W-1:0]  mem [bsp_pkg::DEPTH];   // array
	logic [bsp_pkg::DATA_W-1:0]  rbuf [2][bsp_pkg::BURST]; // ping-pong read bursts
	logic                        rd_sel;                 // buffer of the newest burst
	logic                        push_valid, push_ready, pop_valid, pop_ready;
	logic [bsp_pkg::ENTRY_W-1:0] push_data, pop_data;
	logic [bsp_pkg::WADDR_W-1:0] pa;                     // pair address leaving the fifo
	logic [bsp_pkg::DATA_W-1:0]  pd0, pd1;
	logic [bsp_pkg::MASK_W-1:0]  pm0, pm1;
	logic [bsp_pkg::WADDR_W-1:0] fbase;                  // fetch base
	logic                        n_seen, n_two, oe_neg, p_seen, p_two, oe_pos; // fall and rise launch state
	logic [bsp_pkg::DATA_W-1:0]  q_neg, q_pos;
	logic                        bl_k, bl_s1, bl_s2, sm_s1, sm_s2; // link backlog and the backlog and mode synchronisers
	//------------------------------------------------------------
	// strap and output clock choice
	//------------------------------------------------------------
	// both output clocks high after reset selects single mode; taken once the sampler holds a real value
	always_ff @(posedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_s1    <= 1'b0;
			strap_s2    <= 1'b0;
			strap_v1    <= 1'b0;
			strap_v2    <= 1'b0;
			strap_done  <= 1'b0;
			single_mode <= 1'b0;
		end else begin
			strap_s1 <= c_clk_i & cb_clk_i;
			strap_s2 <= strap_s1;
			strap_v1 <= 1'b1;
			strap_v2 <= strap_v1;
			if (strap_v2 && !strap_done) begin
				strap_done  <= 1'b1;
				single_mode <= strap_s2;                 // [R15]
			end
		end
	end
	assign oclk = single_mode ? k_clk_i : c_clk_i;       // [R4] [R15]
	//------------------------------------------------------------
	// request arbitration
	//------------------------------------------------------------
	// a select repeated on the rise after its access started is ignored; write yields to read
	assign rd_go = !read_port_select_n_i && !prev_rd;                          // [R5] [R6] [R14]
	assign wr_go = !write_port_select_n_i && !prev_wr && !rd_go;               // [R1] [R6] [R13]
	// initiation history and stages; stopped clocks simply freeze these
	always_ff @(posedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_rd <= 1'b0;                             // [R11]
			prev_wr <= 1'b0;
			rd_s1   <= 1'b0;
			ws1     <= 1'b0;
			ws2     <= 1'b0;
			ws3     <= 1'b0;
			ra      <= '0;
			wa      <= '0;
			wnext   <= '0;
		end else begin
			prev_rd <= rd_go;                            // [R12]
			prev_wr <= wr_go;
			rd_s1   <= rd_go;
			ws1     <= wr_go;
			ws2     <= ws1;
			ws3     <= ws2;
			if (rd_go) ra <= addr_i;
			if (wr_go) wa <= addr_i;
			if (ws2) wnext <= {wa, bsp_pkg::BURST_LSB} + bsp_pkg::PAIR_STEP;
		end
	end
	//------------------------------------------------------------
	// write data capture
	//------------------------------------------------------------
	// rising edge word with its own mask
	always_ff @(posedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			d_lo <= '0;
			m_lo <= bsp_pkg::MASK_NONE;
		end else begin
			d_lo <= wdata_i;                             // [R4]
			m_lo <= byte_write_mask_n_i;                 // [R10]
		end
	end
	// inverted rise word with its own mask
	always_ff @(negedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			d_hi <= '0;
			m_hi <= bsp_pkg::MASK_NONE;
		end else begin
			d_hi <= wdata_i;                             // [R4]
			m_hi <= byte_write_mask_n_i;                 // [R10]
		end
	end
	// pairs of t+1 and t+2 go to the fifo; data is ignored otherwise
	assign push_valid = ws2 | ws3;                       // [R1] [R13]
	assign push_data  = {(ws2 ? {wa, bsp_pkg::BURST_LSB} : wnext), m_lo, d_lo, m_hi, d_hi};
	bsp_fifo #(
		.W (bsp_pkg::ENTRY_W),
		.D (bsp_pkg::FIFO_D)
	) u_fifo (
		.clk_i       (k_clk_i),
		.rst_i       (sys_rst_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (push_data),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (pop_data)
	);
	assign {pa, pm0, pd0, pm1, pd1} = pop_data;
	// the array is busy fetching in a read's first cycle
	assign pop_ready = !rd_s1;
	// fill state shown to the host
	always_ff @(posedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ready_o <= 1'b0;
			bl_k       <= 1'b0;
		end else begin
			wr_ready_o <= push_ready;
			bl_k       <= pop_valid;
		end
	end
	//------------------------------------------------------------
	// array
	//------------------------------------------------------------
	// masked lanes keep their contents
	always_ff @(posedge k_clk_i) begin
		if (pop_valid && pop_ready) begin
			if (pm0 != bsp_pkg::MASK_NONE) begin         // [R9]
				mem[pa] <= (mem[pa] & ~bsp_pkg::lane_en(pm0)) | (pd0 & bsp_pkg::lane_en(pm0)); // [R7] [R8]
			end
			if (pm1 != bsp_pkg::MASK_NONE) begin         // [R9]
				mem[pa + bsp_pkg::WORD_STEP] <= (mem[pa + bsp_pkg::WORD_STEP] & ~bsp_pkg::lane_en(pm1))
					| (pd1 & bsp_pkg::lane_en(pm1));     // [R3] [R7] [R8]
			end
		end
	end
	assign fbase = {ra, bsp_pkg::BURST_LSB};
	// fetch the whole burst into the idle buffer at t+1
	always_ff @(posedge k_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_sel <= 1'b0;
		end else if (rd_s1) begin
			rd_sel <= ~rd_sel;
			for (int i = 0; i < bsp_pkg::BURST; i++) begin
				rbuf[~rd_sel][i] <= mem[fbase + bsp_pkg::WADDR_W'(i)];  // [R3]
			end
		end
	end
	//------------------------------------------------------------
	// read launch
	//------------------------------------------------------------
	// inverted rises carry words 0 and 2
	always_ff @(negedge oclk or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			n_seen <= 1'b0;
			n_two  <= 1'b0;
			oe_neg <= 1'b0;                              // [R11]
			q_neg  <= '0;
		end else if (rd_sel != n_seen) begin
			n_seen <= rd_sel;
			n_two  <= 1'b1;
			oe_neg <= 1'b1;
			q_neg  <= rbuf[rd_sel][0];                   // [R2]
		end else if (n_two) begin
			n_two <= 1'b0;
			q_neg <= rbuf[rd_sel][2];                    // [R2]
		end else begin
			oe_neg <= 1'b0;                              // [R13]
		end
	end
	// rises carry words 1 and 3
	always_ff @(posedge oclk or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			p_seen <= 1'b0;
			p_two  <= 1'b0;
			oe_pos <= 1'b0;                              // [R11]
			q_pos  <= '0;
		end else if (p_seen != n_seen) begin
			p_seen <= n_seen;
			p_two  <= 1'b1;
			oe_pos <= 1'b1;
			q_pos  <= rbuf[n_seen][1];                   // [R2]
		end else if (p_two) begin
			p_two <= 1'b0;
			q_pos <= rbuf[p_seen][3];                    // [R2]
		end else begin
			oe_pos <= 1'b0;                              // [R13]
		end
	end
	// double rate select: each half shows the register of its edge
	assign rdata_o    = oclk ? q_pos : q_neg;            // [R4]
	assign rdata_oe_o = oclk ? oe_pos : oe_neg;
	//------------------------------------------------------------
	// status toward the system clock
	//------------------------------------------------------------
	// two-flop synchronisers for levels
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bl_s1         <= 1'b0;
			bl_s2         <= 1'b0;
			sm_s1         <= 1'b0;
			sm_s2         <= 1'b0;
			wr_backlog_o  <= 1'b0;
			single_mode_o <= 1'b0;
		end else begin
			bl_s1         <= bl_k;
			bl_s2         <= bl_s1;
			sm_s1         <= single_mode;
			sm_s2         <= sm_s1;
			wr_backlog_o  <= bl_s2;
			single_mode_o <= sm_s2;
		end
	end
	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	logic [bsp_pkg::DATA_W-1:0] chk_w3, chk_old;
	assign chk_w3  = mem[fbase + bsp_pkg::WADDR_W'(3)];
	assign chk_old = mem[pa];
	rd_spacing_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R6]
		rd_s1 |=> !rd_s1) else $error("read started on consecutive rises");
	wr_spacing_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R6]
		ws1 |=> !ws1) else $error("write started on consecutive rises");
	rd_priority_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R14]
		(!read_port_select_n_i && !write_port_select_n_i && !prev_rd && !prev_wr) |=> (rd_s1 && !ws1))
		else $error("read lost priority from idle");
	wr_after_rd_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R5]
		(prev_rd && !write_port_select_n_i && !prev_wr) |=> ws1) else $error("write refused after read");
	nop_idle_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R13]
		(read_port_select_n_i && write_port_select_n_i) |=> (!rd_s1 && !ws1)) else $error("op without select");
	wr_pairs_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R1]
		wr_go |-> ##2 push_valid ##1 push_valid) else $error("write pairs not taken at t+2 and t+3");
	rd_launch_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i || !single_mode) // [R2]
		rd_go |-> ##3 (oe_pos && p_two)) else $error("read word 1 not launched at t+2");
	burst_order_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R3]
		rd_s1 |=> (rbuf[rd_sel][3] == $past(chk_w3))) else $error("last burst word from wrong address");
	mask_keep_a: assert property (@(posedge k_clk_i) disable iff (sys_rst_i) // [R9]
		(pop_valid && pop_ready && pm0 == bsp_pkg::MASK_NONE) |=> (mem[$past(pa)] == $past(chk_old)))
		else $error("masked word was changed");
	reset_off_a: assert property (@(posedge k_clk_i) // [R11]
		$past(sys_rst_i) && !sys_rst_i |-> (!oe_pos && !oe_neg && !prev_rd && !prev_wr))
		else $error("port not idle after reset");
	rd_wr_alt_c: cover property (@(posedge k_clk_i) disable iff (sys_rst_i) rd_go ##1 wr_go ##1 rd_go);
	fifo_full_c: cover property (@(posedge k_clk_i) disable iff (sys_rst_i) push_valid && !push_ready);
	rd_back_c: cover property (@(posedge k_clk_i) disable iff (sys_rst_i) rd_go ##2 rd_go);
endmodule
`default_nettype wire

// >>> include/bsp_pkg.sv
// constants and helpers for the burst memory port
// assumes one includer compiles it before the design file
`default_nettype none
package bsp_pkg;
	//------------------------------------------------------------
	// widths and depths
	//------------------------------------------------------------
	localparam int DATA_W  = 18;                        // word width on both data ports
	localparam int LO_W    = 9;                         // low lane width, 4 for the 8-bit part
	localparam int MASK_W  = 2;                         // one mask select per lane
	localparam int BADDR_W = 6;                         // burst address pins
	localparam int WADDR_W = BADDR_W + 2;               // word address inside the array
	localparam int DEPTH   = 1 << WADDR_W;              // words held by the array
	localparam int BURST   = 4;                         // words per access
	localparam int FIFO_D  = 4;                         // write pairs waiting for the array
	localparam int ENTRY_W = WADDR_W + 2 * (DATA_W + MASK_W);
	//------------------------------------------------------------
	// fixed values
	//------------------------------------------------------------
	localparam logic [1:0]         BURST_LSB = 2'h0;    // burst starts on a four-word boundary
	localparam logic [WADDR_W-1:0] PAIR_STEP = 8'h02;   // second pair of a write burst
	localparam logic [WADDR_W-1:0] WORD_STEP = 8'h01;   // next word of a pair
	localparam logic [MASK_W-1:0]  MASK_NONE = 2'h3;    // every lane masked off
	// lane enables from active-low mask selects
	function automatic logic [DATA_W-1:0] lane_en(input logic [MASK_W-1:0] mask_n);
		logic [DATA_W-1:0] en;
		en = '0;
		for (int i = 0; i < DATA_W; i++) begin
			en[i] = (i < LO_W) ? ~mask_n[0] : ~mask_n[1];
		end
		return en;
	endfunction
endpackage
`default_nettype wire

// >>> test/bsp_host.sv
// host controller model: input clock, selects, address, write data and masks
// assumes the port samples requests on the input clock rise and data on both edges
`default_nettype none
module bsp_host (
	output logic                            k_clk_o,     // input clock, parks high when stopped
	output logic                            rd_sel_n_o,  // read select, low asks
	output logic                            wr_sel_n_o,  // write select, low asks
	output logic [bsp_pkg::BADDR_W-1:0]     addr_o,      // burst address
	output logic [bsp_pkg::DATA_W-1:0]      wdata_o,     // write data, one word per edge
	output logic [bsp_pkg::MASK_W-1:0]      wmask_n_o,   // active-low lane selects
	input  wire logic [bsp_pkg::DATA_W-1:0] rdata_i,     // read data from the port
	input  wire logic                       rdata_oe_i   // read data drive enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic k_run;  // clock runs while high
	initial begin
		k_clk_o = 1'b1;
		k_run = 1'b1;
		rd_sel_n_o = 1'b1;
		wr_sel_n_o = 1'b1;
		addr_o = 6'h00;
		wdata_o = 18'h00000;
		wmask_n_o = 2'h0;
	end
	// half period 24 ns; a stopped clock finishes its low phase and parks high
	always begin
		#24;
		if (k_run || !k_clk_o) k_clk_o = ~k_clk_o;
	end
	// stop the clock for n cycles, state must hold meanwhile
	task automatic pause(input int n);
		k_run = 1'b0;
		#(n * 48);
		k_run = 1'b1;
	endtask
	// one access window of four cycles; wt is the rise (0 or 1) whose write owns the data
	task automatic burst(input logic rd0, wr0, rd1, wr1, input int wt,
		input logic [bsp_pkg::BADDR_W-1:0] a0, a1, input logic [bsp_pkg::DATA_W-1:0] d [4],
		input logic [bsp_pkg::MASK_W-1:0] m [4], output logic [bsp_pkg::DATA_W-1:0] q [4],
		output logic [3:0] oe, output logic oe_end);
		int wi;
		@(negedge k_clk_o);
		#12;
		rd_sel_n_o = ~rd0;
		wr_sel_n_o = ~wr0;
		addr_o = a0;
		for (int e = 0; e < 8; e++) begin
			if (e[0]) @(negedge k_clk_o);
			else @(posedge k_clk_o);
			#12;
			if (e >= 3 && e <= 6) begin
				q[e-3] = rdata_i;
				oe[e-3] = rdata_oe_i;
			end
			if (e == 7) oe_end = rdata_oe_i;
			// words for t+1 and t+2 of the write, anything else keeps changing
			wi = e + 1 - 2 * (wt + 1);
			wdata_o = (wi >= 0 && wi < 4) ? d[wi] : ~wdata_o;
			wmask_n_o = (wi >= 0 && wi < 4) ? m[wi] : ~wmask_n_o;
			if (e == 1) begin
				rd_sel_n_o = ~rd1;
				wr_sel_n_o = ~wr1;
				addr_o = a1;
			end
			if (e == 3) begin
				rd_sel_n_o = 1'b1;
				wr_sel_n_o = 1'b1;
				addr_o = ~addr_o;
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the burst memory port
// assumes bsp_pkg and the host model are compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DW = bsp_pkg::DATA_W;
	logic                          mclk, rst, strap;  // system clock, reset, output clock strap
	wire                           k_clk, c_clk, cb_clk, rd_sel_n, wr_sel_n;
	wire [bsp_pkg::BADDR_W-1:0]    addr;
	wire [DW-1:0]                  wdata, rdata;
	wire [bsp_pkg::MASK_W-1:0]     mask_n;
	wire                           rdata_oe, wr_ready, backlog, single_mode;
	logic [DW-1:0]                 mdl [bsp_pkg::DEPTH];  // expected array contents
	logic [DW-1:0]                 d [4], q [4];
	logic [bsp_pkg::MASK_W-1:0]    m [4];
	logic [3:0]                    oe;
	logic                          oe_end;
	logic [bsp_pkg::BADDR_W-1:0]   a, wa;
	integer                        seed;
	int                            n_mismatch, n_compared;
	always #50 mclk = ~mclk;
	// output clocks trail the input clock slightly, so the strap never sees a half-updated pair
	assign #1 c_clk = strap ? 1'b1 : k_clk;
	assign #1 cb_clk = strap ? 1'b1 : ~k_clk;
	bsp_port u_bsp_port (.mclk_i(mclk), .sys_rst_i(rst), .k_clk_i(k_clk), .c_clk_i(c_clk),
		.cb_clk_i(cb_clk), .read_port_select_n_i(rd_sel_n), .write_port_select_n_i(wr_sel_n),
		.addr_i(addr), .wdata_i(wdata), .byte_write_mask_n_i(mask_n), .rdata_o(rdata),
		.rdata_oe_o(rdata_oe), .wr_ready_o(wr_ready), .wr_backlog_o(backlog), .single_mode_o(single_mode));
	bsp_host u_bsp_host (.k_clk_o(k_clk), .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n), .addr_o(addr),
		.wdata_o(wdata), .wmask_n_o(mask_n), .rdata_i(rdata), .rdata_oe_i(rdata_oe));
	// lane-wise merge of a masked word into the stored word
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w, new_w,
		input logic [bsp_pkg::MASK_W-1:0] mk);
		logic [DW-1:0] r;
		for (int i = 0; i < DW; i++) r[i] = ((i < bsp_pkg::LO_W) ? mk[0] : mk[1]) ? old_w[i] : new_w[i];
		return r;
	endfunction
	task automatic chk_word(input string what, input logic [DW-1:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// random words; masks all low for a full write
	task automatic fill(input logic full);
		for (int i = 0; i < 4; i++) begin
			d[i] = DW'($random(seed));
			m[i] = full ? 2'h0 : 2'($random(seed));
		end
	endtask
	task automatic upd(input logic [bsp_pkg::BADDR_W-1:0] wa_i);
		for (int i = 0; i < 4; i++) mdl[{wa_i, 2'h0} + i] = merge(mdl[{wa_i, 2'h0} + i], d[i], m[i]);
	endtask
	// write burst; dup repeats the select on the next rise, which must be dropped
	task automatic do_wr(input logic [bsp_pkg::BADDR_W-1:0] wa_i, input logic full, dup);
		fill(full);
		u_bsp_host.burst(1'b0, 1'b1, 1'b0, dup, 0, wa_i, wa_i, d, m, q, oe, oe_end);
		upd(wa_i);
	endtask
	task automatic do_rd(input logic [bsp_pkg::BADDR_W-1:0] ra);
		u_bsp_host.burst(1'b1, 1'b0, 1'b0, 1'b0, -1, ra, ra, d, m, q, oe, oe_end);
		for (int i = 0; i < 4; i++) begin
			chk_word("read word", mdl[{ra, 2'h0} + i], q[i]);
			chk_bit("read enable", 1'b1, oe[i]);
		end
		chk_bit("enable after burst", 1'b0, oe_end);
	endtask
	// wait, bounded, until pending write pairs reach the array
	task automatic drain();
		int n;
		n = 0;
		repeat (5) @(negedge mclk);
		while (backlog !== 1'b0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		if (n == 200) begin
			n_mismatch++;
			$display("[FAIL] write backlog expected 0 seen %b", backlog);
			print_verdict();
		end
		repeat (2) @(negedge mclk);
	endtask
	task automatic do_reset(input logic s);
		strap = s;
		rst = 1'b1;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (6) @(posedge k_clk);
		repeat (5) @(negedge mclk);
		chk_bit("single mode", s, single_mode);
		chk_bit("idle enable", 1'b0, rdata_oe);
		chk_bit("write room", 1'b1, wr_ready);
	endtask
	// whole-run limit: a hang counts as a mismatch and ends in the verdict
	initial begin
		repeat (20000) @(negedge mclk);
		n_mismatch++;
		$display("[FAIL] run end expected done seen timeout");
		print_verdict();
	end
	initial begin
		seed = 32'h86b2;
		mclk = 1'b0;
		rst = 1'b1;
		strap = 1'b0;
		n_mismatch = 0;
		n_compared = 0;
		do_reset(1'b0);
		// edge addresses first, then random ones; full write, masked write, read back
		for (int it = 0; it < 16; it++) begin
			a = (it == 0) ? 6'h00 : (it == 1) ? 6'h3f : 6'($random(seed));
			do_wr(a, 1'b1, 1'b0);
			do_wr(a, 1'b0, it[0]);
			drain();
			do_rd(a);
		end
		// both selects from idle: read first, write on the next rise
		wa = a + 6'h01;
		do_wr(wa, 1'b1, 1'b0);
		drain();
		fill(1'b1);
		u_bsp_host.burst(1'b1, 1'b1, 1'b1, 1'b1, 1, a, wa, d, m, q, oe, oe_end);
		for (int i = 0; i < 4; i++) chk_word("shared read", mdl[{a, 2'h0} + i], q[i]);
		chk_bit("no second read", 1'b0, oe_end);
		upd(wa);
		drain();
		do_rd(a);
		do_rd(wa);
		// nothing selected: data ignored, outputs off
		fill(1'b1);
		u_bsp_host.burst(1'b0, 1'b0, 1'b0, 1'b0, 0, wa, wa, d, m, q, oe, oe_end);
		chk_bit("idle enable", 1'b0, |oe | oe_end);
		drain();
		do_rd(wa);
		// stopped clock holds contents
		u_bsp_host.pause(20);
		repeat (2) @(posedge k_clk);
		#12;
		chk_bit("enable after stop", 1'b0, rdata_oe);
		do_rd(wa);
		// strapped output clocks: output launched from the input clock
		do_reset(1'b1);
		do_wr(6'h15, 1'b1, 1'b0);
		do_wr(6'h15, 1'b0, 1'b0);
		drain();
		do_rd(6'h15);
		print_verdict();
	end
endmodule
`default_nettype wire
